// ---- hdl/ofs_pkg.sv ----
// constants shared by the output driver fault supervisor
// assumes a single 10 MHz clock and an active-low asynchronous reset
//
// Operation
// - the high-side driver follows the enable bit of the high-side control register.
// - with enable and pwm select set, the high-side driver follows the pwm input pin.
// - low high-side current in Normal or Normal Request sets open-load status bit 1.
// - high-side current limitation keeps the driver on and sets status bit 0.
// - high-side overtemperature turns the driver off and sets both high-side flags.
// - high-side overtemperature latches source code 0010 and pulls the interrupt low.
// - the high-side interrupt is raised only while the high-side mask bit is set.
// - a high-side thermal shutdown holds until a control write once the heat is gone.
// - low-side heat stops both low sides, sets all four low-side flags, reports 0011, waits for a write.
// - low-side current limitation keeps the driver on and sets bit 0 (a) or bit 2 (b).
// - a floating watchdog config pin selects the internal timebase and sets status bit 2.
// - in Reset a regulator undervoltage without supply undervoltage leads to Sleep.
// - fault interrupts arise only in Normal, Normal Request and Stop; flags stay readable.
// - a masked fault source keeps the interrupt line high and sets no source code.
// - an unanswered Normal Request times out after 150 ms into Reset and a host reset.
// - a clear in the closed half or an overflow resets the host and sets the timeout flag.

package ofs_pkg;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OFS_RESET   = 3'b000,
    OFS_NORMREQ = 3'b001,
    OFS_NORMAL  = 3'b010,
    OFS_STOP    = 3'b011,
    OFS_SLEEP   = 3'b100
  } ofs_mode_t;

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int HS_CL_BIT   = 0;
  localparam int HS_OL_BIT   = 1;
  localparam int LS_A_CL_BIT = 0;
  localparam int LS_A_OL_BIT = 1;
  localparam int LS_B_CL_BIT = 2;
  localparam int LS_B_OL_BIT = 3;
  localparam int WD_ERR_BIT  = 2;
  localparam int WD_TO_BIT   = 3;

  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_HS   = 4'h2;
  localparam logic [3:0] SRC_LS   = 4'h3;

  localparam logic [1:0] HS_STAT_RST = 2'h0;
  localparam logic [3:0] LS_STAT_RST = 4'h0;
  localparam logic [3:0] WD_STAT_RST = 4'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS         = 100;
  localparam int NREQ_TIMEOUT_MS = 150;
  localparam int NREQ_CYCLES    = (NREQ_TIMEOUT_MS * 1000000) / CLK_NS;
  localparam int HOST_RST_CYCLES = 16;
  localparam int WD_CNT_W       = 24;

endpackage : ofs_pkg

// ---- hdl/ofs_sync.sv ----
// two-flop synchroniser for a bundle of comparator levels
// assumes levels arrive from analog comparators unrelated to the clock
`timescale 1ns/10ps

module ofs_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,  // system clock
  input  wire logic         rst_b,  // async reset, active low
  input  wire logic [W-1:0] async_in, // raw comparator levels
  output logic      [W-1:0] sync_out  // synchronised levels
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : ofs_sync

// ---- hdl/ofs_top.sv ----
// output driver fault supervisor: high-side and low-side gating, fault flags,
// interrupt sources and the mode sequencer
// assumes control and status bits are plain ports; writes are one-cycle pulses
`timescale 1ns/10ps

module ofs_top (
  input  wire logic       clock,                 // 10 MHz clock
  input  wire logic       rst_b,                 // async reset, active low
  input  wire logic       high_side_enable,      // control bit, high side on
  input  wire logic       high_side_pwm_select,  // high side follows pwm pin
  input  wire logic       high_side_ctrl_wr,     // high-side control write pulse
  input  wire logic [1:0] low_side_enable,       // control bits, low sides on
  input  wire logic [1:0] low_side_pwm_select,   // low sides follow pwm pin
  input  wire logic       low_side_ctrl_wr,      // low-side control write pulse
  input  wire logic       pwm_input_pin,         // direct pwm input
  input  wire logic       high_side_irq_mask,    // 1 enables high-side interrupt
  input  wire logic       low_side_irq_mask,     // 1 enables low-side interrupt
  input  wire logic       source_rd,             // source read pulse, clears code
  input  wire logic       status_rd,             // status read pulse, clears flags
  input  wire logic       hs_open_cmp,           // raw open-load comparator
  input  wire logic       hs_limit_cmp,          // raw current-limit comparator
  input  wire logic       hs_hot_cmp,            // raw overtemperature comparator
  input  wire logic [1:0] ls_open_cmp,           // raw low-side open-load
  input  wire logic [1:0] ls_limit_cmp,          // raw low-side current-limit
  input  wire logic       ls_hot_cmp,            // raw low-side overtemperature
  input  wire logic       wdog_floating,         // config pin seen floating
  input  wire logic       go_normal,             // host commands normal
  input  wire logic       go_stop,               // host commands stop
  input  wire logic       wd_clear,              // watchdog clear pulse
  input  wire logic [23:0] wd_period,            // watchdog window in cycles
  input  wire logic       reg_uv,                // regulator undervoltage
  input  wire logic       supply_undervoltage_flag, // supply undervoltage flag
  input  wire logic       wake,                  // wake-up event
  output logic            high_side_drive,       // high-side gate
  output logic [1:0]      low_side_drive,        // low-side gates
  output logic [1:0]      high_side_status_reg,  // {open load, current limit}
  output logic [3:0]      low_side_status_reg,   // {b ol, b cl, a ol, a cl}
  output logic [3:0]      interrupt_source_reg,  // latched source code
  output logic [3:0]      watchdog_status_reg,   // watchdog status bits
  output logic            irq_b,                 // interrupt line, active low
  output logic            internal_timebase,     // watchdog on internal timebase
  output logic            host_rst_b,            // host reset, active low
  output logic [2:0]      mode_out               // current mode
);

  // ----------------------------------------------------------------
  // comparator synchronisation
  // ----------------------------------------------------------------
  logic [8:0] cmp_s;
  ofs_sync #(.W(9)) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in ({wdog_floating, ls_hot_cmp, ls_limit_cmp, ls_open_cmp,
                hs_hot_cmp, hs_limit_cmp, hs_open_cmp}),
    .sync_out (cmp_s)
  );
  wire logic       hs_open  = cmp_s[0];
  wire logic       hs_limit = cmp_s[1];
  wire logic       hs_hot   = cmp_s[2];
  wire logic [1:0] ls_open  = cmp_s[4:3];
  wire logic [1:0] ls_limit = cmp_s[6:5];
  wire logic       ls_hot   = cmp_s[7];
  wire logic       wd_float = cmp_s[8];

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  ofs_pkg::ofs_mode_t mode;
  logic               host_rst;
  logic               wd_to;
  ofs_wdog u_wdog (
    .clock                    (clock),
    .rst_b                    (rst_b),
    .go_normal                (go_normal),
    .go_stop                  (go_stop),
    .wd_clear                 (wd_clear),
    .wd_period                (wd_period),
    .reg_uv                   (reg_uv),
    .supply_undervoltage_flag (supply_undervoltage_flag),
    .wake                     (wake),
    .mode                     (mode),
    .host_rst                 (host_rst),
    .wd_timeout               (wd_to)
  );

  wire logic run_mode = (mode == ofs_pkg::OFS_NORMAL) || (mode == ofs_pkg::OFS_NORMREQ);
  wire logic irq_mode = run_mode || (mode == ofs_pkg::OFS_STOP);

  // ----------------------------------------------------------------
  // shutdown latches and drive gating
  // ----------------------------------------------------------------
  logic hs_off_q;
  logic ls_off_q;
  wire logic hs_want    = high_side_enable && (!high_side_pwm_select || pwm_input_pin);
  wire logic [1:0] ls_want = low_side_enable & (~low_side_pwm_select | {2{pwm_input_pin}});
  wire logic hs_off_d   = hs_hot || (hs_off_q && !high_side_ctrl_wr);
  wire logic ls_off_d   = ls_hot || (ls_off_q && !low_side_ctrl_wr);
  // stop and sleep keep the low sides off; high side stays usable for sensing
  wire logic ls_allowed = run_mode && !ls_off_d;

  // ----------------------------------------------------------------
  // status flags: hardware set wins over read clear
  // ----------------------------------------------------------------
  wire logic [1:0] hs_set = {hs_open && run_mode, hs_limit} | {2{hs_hot}};
  wire logic [3:0] ls_set = {ls_open[1] && run_mode, ls_limit[1],
                             ls_open[0] && run_mode, ls_limit[0]} | {4{ls_hot}};
  wire logic [1:0] hs_stat_d = hs_set | (status_rd ? 2'h0 : high_side_status_reg);
  wire logic [3:0] ls_stat_d = ls_set | (status_rd ? 4'h0 : low_side_status_reg);

  // ----------------------------------------------------------------
  // interrupt sources
  // ----------------------------------------------------------------
  logic hs_hot_q;
  logic ls_hot_q;
  wire logic hs_evt = hs_hot && !hs_hot_q && irq_mode && high_side_irq_mask;
  wire logic ls_evt = ls_hot && !ls_hot_q && irq_mode && low_side_irq_mask;
  wire logic [3:0] src_d = hs_evt ? ofs_pkg::SRC_HS :
                           ls_evt ? ofs_pkg::SRC_LS :
                           source_rd ? ofs_pkg::SRC_NONE : interrupt_source_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hs_off_q             <= 1'b0;
      ls_off_q             <= 1'b0;
      hs_hot_q             <= 1'b0;
      ls_hot_q             <= 1'b0;
      high_side_drive      <= 1'b0;
      low_side_drive       <= 2'h0;
      high_side_status_reg <= ofs_pkg::HS_STAT_RST;
      low_side_status_reg  <= ofs_pkg::LS_STAT_RST;
      interrupt_source_reg <= ofs_pkg::SRC_NONE;
      watchdog_status_reg  <= ofs_pkg::WD_STAT_RST;
      irq_b                <= 1'b1;
      internal_timebase    <= 1'b0;
      host_rst_b           <= 1'b0;
      mode_out             <= 3'h0;
    end else begin
      hs_off_q             <= hs_off_d;
      ls_off_q             <= ls_off_d;
      hs_hot_q             <= hs_hot;
      ls_hot_q             <= ls_hot;
      high_side_drive      <= hs_want && !hs_off_d;
      low_side_drive       <= ls_want & {2{ls_allowed}};
      high_side_status_reg <= hs_stat_d;
      low_side_status_reg  <= ls_stat_d;
      interrupt_source_reg <= src_d;
      irq_b                <= (src_d == ofs_pkg::SRC_NONE);
      internal_timebase    <= wd_float;
      watchdog_status_reg[ofs_pkg::WD_ERR_BIT] <= wd_float;
      watchdog_status_reg[ofs_pkg::WD_TO_BIT]  <= wd_to ||
        (watchdog_status_reg[ofs_pkg::WD_TO_BIT] && !status_rd);
      watchdog_status_reg[1:0] <= 2'h0;
      host_rst_b           <= !host_rst;
      mode_out             <= mode;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hs_thermal_off_a: assert property (@(posedge clock) disable iff (!rst_b)
    hs_hot |=> !high_side_drive && (high_side_status_reg == 2'h3))
    else $error("high side not shut down on overtemperature");
  hs_stay_off_a: assert property (@(posedge clock) disable iff (!rst_b)
    hs_off_q && !high_side_ctrl_wr |=> !high_side_drive)
    else $error("high side re-enabled without control write");
  hs_pwm_follow_a: assert property (@(posedge clock) disable iff (!rst_b)
    high_side_enable && high_side_pwm_select && !pwm_input_pin |=> !high_side_drive)
    else $error("high side on while pwm low");
  hs_irq_code_a: assert property (@(posedge clock) disable iff (!rst_b)
    hs_evt |=> interrupt_source_reg == ofs_pkg::SRC_HS && !irq_b)
    else $error("high side source code missing");
  irq_masked_a: assert property (@(posedge clock) disable iff (!rst_b)
    hs_hot && !hs_hot_q && !high_side_irq_mask && !ls_evt && interrupt_source_reg == 4'h0
    && !source_rd |=> irq_b)
    else $error("masked source raised interrupt");
  ls_thermal_off_a: assert property (@(posedge clock) disable iff (!rst_b)
    ls_hot |=> low_side_drive == 2'h0 && low_side_status_reg == 4'hF)
    else $error("low sides not shut down");
  ls_limit_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
    ls_limit[1] |=> low_side_status_reg[ofs_pkg::LS_B_CL_BIT])
    else $error("low side b limit flag missing");
  sleep_on_uv_a: assert property (@(posedge clock) disable iff (!rst_b)
    mode == ofs_pkg::OFS_RESET && reg_uv && !supply_undervoltage_flag
    |=> mode == ofs_pkg::OFS_SLEEP)
    else $error("reset mode did not go to sleep");

endmodule : ofs_top

// ---- hdl/ofs_wdog.sv ----
// mode sequencer: normal-request timeout, window watchdog and reset mode exit
// assumes host commands are one-cycle pulses synchronous to clock
`timescale 1ns/10ps

module ofs_wdog #(
  parameter int NREQ_CYC = ofs_pkg::NREQ_CYCLES
) (
  input  wire logic                     clock,        // system clock
  input  wire logic                     rst_b,        // async reset, active low
  input  wire logic                     go_normal,    // host commands normal mode
  input  wire logic                     go_stop,      // host commands stop mode
  input  wire logic                     wd_clear,     // watchdog clear pulse
  input  wire logic [ofs_pkg::WD_CNT_W-1:0] wd_period, // watchdog window length
  input  wire logic                     reg_uv,       // regulator undervoltage
  input  wire logic                     supply_undervoltage_flag, // supply uv flag
  input  wire logic                     wake,         // wake-up from stop or sleep
  output ofs_pkg::ofs_mode_t            mode,         // current mode
  output logic                          host_rst,     // host reset pulse level
  output logic                          wd_timeout    // one-cycle timeout event
);

  logic [ofs_pkg::WD_CNT_W-1:0] cnt_q;
  logic [4:0]                   hr_q;
  wire logic nreq_exp = (mode == ofs_pkg::OFS_NORMREQ) && (32'(cnt_q) >= NREQ_CYC - 1);
  wire logic wd_over  = (mode == ofs_pkg::OFS_NORMAL) && (cnt_q >= wd_period);
  wire logic wd_early = (mode == ofs_pkg::OFS_NORMAL) && wd_clear && (cnt_q < (wd_period >> 1));
  wire logic wd_fault = wd_over || wd_early;

  assign host_rst = (mode == ofs_pkg::OFS_RESET);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode       <= ofs_pkg::OFS_RESET;
      cnt_q      <= '0;
      hr_q       <= '0;
      wd_timeout <= 1'b0;
    end else begin
      wd_timeout <= wd_fault;
      case (mode)
        ofs_pkg::OFS_RESET: begin
          cnt_q <= '0;
          if (reg_uv && !supply_undervoltage_flag) begin
            mode <= ofs_pkg::OFS_SLEEP;
          end else if (hr_q == 5'(ofs_pkg::HOST_RST_CYCLES)) begin
            hr_q <= '0;
            mode <= ofs_pkg::OFS_NORMREQ;
          end else begin
            hr_q <= hr_q + 5'h1;
          end
        end
        ofs_pkg::OFS_NORMREQ: begin
          cnt_q <= cnt_q + 1'b1;
          if (nreq_exp) begin
            mode <= ofs_pkg::OFS_RESET;
          end else if (go_normal) begin
            mode  <= ofs_pkg::OFS_NORMAL;
            cnt_q <= '0;
          end
        end
        ofs_pkg::OFS_NORMAL: begin
          cnt_q <= wd_clear ? '0 : cnt_q + 1'b1;
          if (wd_fault) begin
            mode <= ofs_pkg::OFS_RESET;
          end else if (go_stop) begin
            mode <= ofs_pkg::OFS_STOP;
          end
        end
        ofs_pkg::OFS_STOP: begin
          // a leftover watchdog count must not shorten the next normal-request timeout
          cnt_q <= '0;
          if (wake) mode <= ofs_pkg::OFS_NORMREQ;
        end
        default: begin
          if (wake) mode <= ofs_pkg::OFS_RESET;
        end
      endcase
    end
  end

endmodule : ofs_wdog

// ---- testbench/ofs_host_model.sv ----
// host microcontroller model: commands normal mode and services the window watchdog
// assumes mode codes 1 = normal request, 2 = normal, and an active-low host reset
`timescale 1ns/10ps

module ofs_host_model #(
  parameter int REPLY_DLY = 5,    // cycles before answering normal request
  parameter int WD_PER    = 1024  // watchdog window in cycles
) (
  input  wire logic       clock,       // system clock
  input  wire logic       rst_b,       // async reset, active low
  input  wire logic [2:0] mode_out,    // device mode
  input  wire logic       host_rst_b,  // host reset from the device
  input  wire logic       early,       // bench asks for a clear in the closed half
  output logic            go_normal,   // normal mode command pulse
  output logic            wd_clear     // watchdog clear pulse
);
  int cnt;
  initial begin
    go_normal = 1'b0;
    wd_clear  = 1'b0;
    cnt       = 0;
    forever begin
      @(posedge clock);
      #1;
      go_normal = 1'b0;
      wd_clear  = 1'b0;
      // a host held in reset stays silent
      if (!rst_b || !host_rst_b || mode_out == 3'h0) begin
        cnt = 0;
      end else if (mode_out == 3'h1) begin
        cnt++;
        if (cnt >= REPLY_DLY) begin
          go_normal = 1'b1;
          cnt       = 0;
        end
      end else if (mode_out == 3'h2) begin
        cnt++;
        // three quarters into the window leaves margin on both sides
        if (cnt >= (early ? 100 : (WD_PER * 3) / 4)) begin
          wd_clear = 1'b1;
          cnt      = 0;
        end
      end
    end
  end
endmodule : ofs_host_model

// ---- testbench/tb.sv ----
// self-checking bench for the output driver fault supervisor
// assumes ofs_top and the host model; expectations are written inline at each check below
`timescale 1ns/10ps

module tb;
  logic       clock, rst_b, hs_en, hs_sel, hs_wr, ls_wr, pwm, hs_mask, ls_mask;
  logic       src_rd, st_rd, hs_open, hs_lim, hs_hot, ls_hot, wd_float, early;
  logic       go_normal, wd_clear, hs_drv, irq_b, itb, host_rst_b;
  logic       go_stop, wake, reg_uv, sv_uv;
  logic [1:0] ls_en, ls_sel, ls_open, ls_lim, ls_drv, hs_st;
  logic [3:0] ls_st, src, wd_st;
  logic [2:0] mode;
  logic [5:0] v;
  int         miscompares, n_checks, seed, m, s;

  ofs_top i_dut (
    .clock(clock), .rst_b(rst_b), .high_side_enable(hs_en), .high_side_pwm_select(hs_sel),
    .high_side_ctrl_wr(hs_wr), .low_side_enable(ls_en), .low_side_pwm_select(ls_sel),
    .low_side_ctrl_wr(ls_wr), .pwm_input_pin(pwm), .high_side_irq_mask(hs_mask),
    .low_side_irq_mask(ls_mask), .source_rd(src_rd), .status_rd(st_rd),
    .hs_open_cmp(hs_open), .hs_limit_cmp(hs_lim), .hs_hot_cmp(hs_hot),
    .ls_open_cmp(ls_open), .ls_limit_cmp(ls_lim), .ls_hot_cmp(ls_hot),
    .wdog_floating(wd_float), .go_normal(go_normal), .go_stop(go_stop), .wd_clear(wd_clear),
    .wd_period(24'h000400), .reg_uv(reg_uv), .supply_undervoltage_flag(sv_uv), .wake(wake),
    .high_side_drive(hs_drv), .low_side_drive(ls_drv), .high_side_status_reg(hs_st),
    .low_side_status_reg(ls_st), .interrupt_source_reg(src), .watchdog_status_reg(wd_st),
    .irq_b(irq_b), .internal_timebase(itb), .host_rst_b(host_rst_b), .mode_out(mode)
  );

  ofs_host_model #(.REPLY_DLY(5), .WD_PER(1024)) i_host (
    .clock(clock), .rst_b(rst_b), .mode_out(mode), .host_rst_b(host_rst_b),
    .early(early), .go_normal(go_normal), .wd_clear(wd_clear)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // bounded wait, since a stuck sequencer must not hang the run
  task automatic wait_mode(input logic [2:0] want);
    int k;
    k = 0;
    while (mode !== want && k < 3000) begin
      step(1);
      k++;
    end
    chk({13'h0, mode}, {13'h0, want});
  endtask : wait_mode

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #2000000;
    miscompares++;
    $display("[ERR] t=%0t watchdog expired got=%h exp=%h", $time, 1'b0, 1'b1);
    wrap_up();
  end

  // ----------------------------------------------------------------
  // stimulus and checks
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {hs_en, hs_sel, hs_wr, ls_wr, pwm, hs_mask, ls_mask, src_rd, st_rd} = '0;
    {go_stop, wake, reg_uv, sv_uv} = 4'h0;
    {hs_open, hs_lim, hs_hot, ls_hot, wd_float, early} = 6'h02;  // config pin floating
    {ls_en, ls_sel, ls_open, ls_lim} = '0;
    miscompares = 0;
    n_checks = 0;
    seed = 88;
    step(12);
    rst_b = 1'b1;
    wait_mode(3'h1);
    wait_mode(3'h2);
    $display("test start done");
    for (int i = 0; i < 32; i++) begin
      {hs_en, hs_sel, pwm, ls_en, ls_sel} = 7'($random(seed));
      step(2);
      chk({ls_drv, hs_drv}, {ls_en & (~ls_sel | {2{pwm}}), hs_en & (~hs_sel | pwm)});
    end
    $display("test gating done");
    {hs_en, hs_sel, pwm, ls_en, ls_sel} = 7'h4C;  // all drivers on, no pwm
    for (int k = 0; k < 6; k++) begin
      v = 6'h01 << k;
      {ls_open[1], ls_lim[1], ls_open[0], ls_lim[0], hs_open, hs_lim} = v;
      step(4);
      chk({10'h0, ls_st, hs_st}, {10'h0, v});
      chk({irq_b, src, ls_drv, hs_drv}, 16'h0087);
      {ls_open, ls_lim, hs_open, hs_lim} = 6'h00;
      step(3);
      st_rd = 1'b1;
      step(1);
      st_rd = 1'b0;
      step(1);
      chk({10'h0, ls_st, hs_st}, 16'h0000);
    end
    $display("test flags done");
    for (int i = 0; i < 4; i++) begin
      s = i % 2;
      m = i / 2;
      hs_mask = m[0];
      ls_mask = m[0];
      hs_hot = (s == 0);
      ls_hot = (s == 1);
      step(4);
      chk({ls_st, hs_st}, (s == 0) ? 6'h03 : 6'h3C);
      chk({ls_drv, hs_drv}, (s == 0) ? 3'h6 : 3'h1);
      chk({irq_b, src}, (m == 0) ? 5'h10 : ((s == 0) ? 5'h02 : 5'h03));
      {hs_hot, ls_hot} = 2'h0;
      step(5);
      chk({ls_drv, hs_drv}, (s == 0) ? 3'h6 : 3'h1);
      hs_wr = (s == 0);
      ls_wr = (s == 1);
      step(1);
      {hs_wr, ls_wr} = 2'h0;
      step(2);
      chk({ls_drv, hs_drv}, 3'h7);
      {src_rd, st_rd} = 2'h3;
      step(1);
      {src_rd, st_rd} = 2'h0;
      step(1);
      chk({irq_b, src, ls_st, hs_st}, 16'h0400);
    end
    $display("test thermal done");
    step(2000);
    chk({host_rst_b, wd_st[3], mode}, {1'b1, 1'b0, 3'h2});
    early = 1'b1;
    s = 0;
    while (host_rst_b !== 1'b0 && s < 1500) begin
      step(1);
      s++;
    end
    early = 1'b0;
    hs_hot = 1'b1;
    step(4);
    chk({host_rst_b, wd_st[3], irq_b, src}, {1'b0, 1'b1, 1'b1, 4'h0});
    hs_hot = 1'b0;
    wait_mode(3'h2);
    hs_wr = 1'b1;
    step(1);
    hs_wr = 1'b0;
    step(2);
    chk({irq_b, src, hs_drv}, 6'h21);
    chk({14'h0, hs_st}, 16'h0003);
    chk({itb, wd_st[2]}, 2'h3);
    $display("test watchdog done");
    // stop mode still reports faults, low sides are held off there
    go_stop = 1'b1;
    step(1);
    go_stop = 1'b0;
    wait_mode(3'h3);
    hs_hot = 1'b1;
    step(4);
    chk({9'h0, irq_b, src, ls_drv}, 16'h0008);
    hs_hot = 1'b0;
    {src_rd, wake} = 2'h3;
    step(1);
    {src_rd, wake} = 2'h0;
    wait_mode(3'h2);
    // second reset with regulator undervoltage and no supply undervoltage
    rst_b = 1'b0;
    reg_uv = 1'b1;
    step(2);
    rst_b = 1'b1;
    step(2);
    chk({13'h0, mode}, 16'h0004);
    sv_uv = 1'b1;
    wake = 1'b1;
    step(1);
    wake = 1'b0;
    wait_mode(3'h1);
    {reg_uv, sv_uv} = 2'h0;
    wait_mode(3'h2);
    $display("test modes done");
    wrap_up();
  end
endmodule : tb
